// >>> rtl/bss_pkg.sv
/*
  Package for the bus stall sleep controller: register offsets, reset
  values, the bus transfer carrier and the state encodings.
  Assumes a single bus clock domain shared by all users of the package.
*/
package bss_pkg;

  // Word offsets of the three registers within the slave's space.
  localparam logic [3:0] BSS_OFF_SLEEP = 4'h0;
  localparam logic [3:0] BSS_OFF_WAKE_SET = 4'h4;
  localparam logic [3:0] BSS_OFF_WAKE_CLR = 4'h8;

  // Reset value of the wake enable vector and of read data.
  localparam logic [31:0] BSS_WAKE_RESET = 32'h0000_0000;
  // Value returned by a read of the sleep entry register.
  localparam logic [31:0] BSS_SLEEP_READ = 32'h0000_0000;

  // Active transfer type codes on the transfer type bus.
  localparam logic [1:0] BSS_TRANS_NONSEQ = 2'h2;
  localparam logic [1:0] BSS_TRANS_SEQ = 2'h3;
  // The only response code this slave issues.
  localparam logic BSS_RESP_OKAY = 1'b0;

  // Address phase information latched for the data phase.
  typedef struct packed {
    logic valid;
    logic write;
    logic [3:0] offset;
  } bss_xfer_t;

  // Sleep sequencing states, one-hot.
  typedef enum logic [3:0] {
    BSS_RUN = 4'b0001,
    BSS_STALL = 4'b0010,
    BSS_GATED = 4'b0100,
    BSS_RELEASE = 4'b1000
  } bss_sleep_t;

  // Debug power-up handshake states, one-hot.
  typedef enum logic [2:0] {
    BSS_DBG_IDLE = 3'b001,
    BSS_DBG_WAKE = 3'b010,
    BSS_DBG_ACK = 3'b100
  } bss_dbg_t;

endpackage

// >>> rtl/bss_sync.sv
/*
  Two flip-flop level synchroniser for the debug power-up request.
  Assumes the input may change at any time relative to the clock.
*/
`timescale 1ns/1ps
module bss_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic d,
  output logic q
);

  // First stage; only the second stage reads it.
  logic meta_reg;
  logic meta_next;
  // Second stage, the safe output.
  logic sync_reg;
  logic sync_next;

  // Next values simply shift the level along.
  always_comb begin
    meta_next = d;
    sync_next = meta_reg;
  end

  // Both stages clear on synchronous reset.
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign q = sync_reg;

endmodule

// >>> rtl/bss_controller.sv
/*
  Bus stall sleep controller: a bus slave that stalls a read of its sleep
  entry register and gates the core clock until a wake event arrives.
  Assumes MCLK runs free and is never gated, and that interrupt lines are
  level sensitive and routed to both the core and this block.
*/
`timescale 1ns/1ps
// Behaviour
// - Reading offset 0x0 requests sleep; read-only.
// - Ones written at 0x4 set enables.
// - Ones written at 0x8 clear enables.
// - Sleep only when no wake event active.
// - Gate stays asserted until a wake event.
// - Sleep is triggered by reads, not writes.
// - Wake is enabled IRQ, NMI or debug.
// - NMI wakes unconditionally, never masked.
// - Transfer needs select, active type, ready.
// - Ready held low during sleep read.
// - Gate asserts the cycle after stall.
// - Wake releases gate first, ready low.
// - Ready returns high one cycle later.
// - Sleep read drives valid read data.
// - Synchronise debug request; it wakes core.
// - Acknowledge after waking, held until released.
// - Debug wake and ack states block sleep.
module bss_controller #(
  parameter int IRQ_WIDTH = 32
) (
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic HWRITE,
  input wire logic [1:0] HTRANS,
  input wire logic [2:0] HSIZE,
  input wire logic [2:0] HBURST,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic HRESP,
  output logic [31:0] HRDATA,
  input wire logic [IRQ_WIDTH-1:0] IRQ,
  input wire logic NMI,
  input wire logic DEBUG_POWERUP_REQUEST,
  output logic DEBUG_POWERUP_ACK,
  output logic SLEEP_GATE
);

  // The register map holds one enable per bit of a 32-bit word.
  initial begin
    if (IRQ_WIDTH < 1 || IRQ_WIDTH > 32) begin
      $error("IRQ_WIDTH must lie between 1 and 32.");
    end
  end

  // Latched address phase of the transfer now in its data phase.
  bss_pkg::bss_xfer_t xfer_reg;
  bss_pkg::bss_xfer_t xfer_next;
  // Wake enable vector, one bit per interrupt line.
  logic [IRQ_WIDTH-1:0] wake_en_reg;
  logic [IRQ_WIDTH-1:0] wake_en_next;
  // Registered read data.
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  // Sleep sequencer state.
  bss_pkg::bss_sleep_t sleep_reg;
  bss_pkg::bss_sleep_t sleep_next;
  // Debug handshake state.
  bss_pkg::bss_dbg_t dbg_reg;
  bss_pkg::bss_dbg_t dbg_next;
  // Synchronised debug request level.
  logic dbg_req_sync;
  // Combined wake request.
  logic wake_request;
  // Debug machine asks to keep the core awake.
  logic dbg_wake;
  // Interrupt and NMI pins synchronised into the bus clock.
  logic [IRQ_WIDTH-1:0] irq_meta_reg;
  logic [IRQ_WIDTH-1:0] irq_sync_reg;
  logic nmi_meta_reg;
  logic nmi_sync_reg;
  // Address phase qualifier and sleep read decode.
  logic addr_phase;
  logic sleep_read;

  // Returns the word-aligned offset field of a bus address.
  function automatic logic [3:0] word_offset(input logic [31:0] addr);
    word_offset = {addr[3:2], 2'b00};
  endfunction

  // Bring the debug request into this clock domain.
  bss_sync u_dbg_sync (
    .clk(MCLK),
    .rst(RESET),
    .d(DEBUG_POWERUP_REQUEST),
    .q(dbg_req_sync)
  );

  // Interrupt pins arrive from other logic and pass two flops first.
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      irq_meta_reg <= '0;
      irq_sync_reg <= '0;
      nmi_meta_reg <= 1'b0;
      nmi_sync_reg <= 1'b0;
    end else begin
      irq_meta_reg <= IRQ;
      irq_sync_reg <= irq_meta_reg;
      nmi_meta_reg <= NMI;
      nmi_sync_reg <= nmi_meta_reg;
    end
  end

  // A transfer is ours only with select, active type and bus ready.
  always_comb begin
    addr_phase = HSEL && HREADY &&
      (HTRANS == bss_pkg::BSS_TRANS_NONSEQ ||
       HTRANS == bss_pkg::BSS_TRANS_SEQ);
    // Only a read of the sleep register starts sleep entry.
    sleep_read = xfer_reg.valid && !xfer_reg.write &&
      xfer_reg.offset == bss_pkg::BSS_OFF_SLEEP;
  end

  // Wake sources combine enabled interrupts, NMI and debug.
  always_comb begin
    wake_request = (|(irq_sync_reg & wake_en_reg)) ||
      nmi_sync_reg ||
      dbg_wake;
  end

  // Debug handshake: wake the core, then acknowledge once it runs.
  always_comb begin
    dbg_next = dbg_reg;
    case (dbg_reg)
      bss_pkg::BSS_DBG_IDLE: begin
        if (dbg_req_sync) begin
          dbg_next = bss_pkg::BSS_DBG_WAKE;
        end
      end
      bss_pkg::BSS_DBG_WAKE: begin
        // Acknowledge only once the core has left sleep.
        if (!dbg_req_sync) begin
          dbg_next = bss_pkg::BSS_DBG_IDLE;
        end else if (sleep_reg == bss_pkg::BSS_RUN) begin
          dbg_next = bss_pkg::BSS_DBG_ACK;
        end
      end
      bss_pkg::BSS_DBG_ACK: begin
        // Hold the acknowledge until the request drops.
        if (!dbg_req_sync) begin
          dbg_next = bss_pkg::BSS_DBG_IDLE;
        end
      end
      default: begin
        dbg_next = bss_pkg::BSS_DBG_IDLE;
      end
    endcase
    dbg_wake = dbg_reg != bss_pkg::BSS_DBG_IDLE;
  end

  // Sleep sequencing: stall, gate, release gate, then finish the read.
  always_comb begin
    sleep_next = sleep_reg;
    case (sleep_reg)
      bss_pkg::BSS_RUN: begin
        // The stall begins in the data phase of a sleep read.
        if (sleep_read && !wake_request) begin
          sleep_next = bss_pkg::BSS_STALL;
        end
      end
      bss_pkg::BSS_STALL: begin
        // The core has seen ready low and the gate is already closed.
        sleep_next = wake_request ? bss_pkg::BSS_RELEASE
                                  : bss_pkg::BSS_GATED;
      end
      bss_pkg::BSS_GATED: begin
        // The gate holds until some wake source appears.
        if (wake_request) begin
          sleep_next = bss_pkg::BSS_RELEASE;
        end
      end
      bss_pkg::BSS_RELEASE: begin
        // Clock runs again; ready stays low, the read completes next cycle in run.
        sleep_next = bss_pkg::BSS_RUN;
      end
      default: begin
        sleep_next = bss_pkg::BSS_RUN;
      end
    endcase
  end

  // Address phase capture, enable updates and read data.
  always_comb begin
    xfer_next = xfer_reg;
    wake_en_next = wake_en_reg;
    rdata_next = rdata_reg;
    // Writes take effect in their data phase.
    if (xfer_reg.valid && xfer_reg.write) begin
      if (xfer_reg.offset == bss_pkg::BSS_OFF_WAKE_SET) begin
        wake_en_next = wake_en_reg | HWDATA[IRQ_WIDTH-1:0];
      end else if (xfer_reg.offset == bss_pkg::BSS_OFF_WAKE_CLR) begin
        wake_en_next = wake_en_reg & ~HWDATA[IRQ_WIDTH-1:0];
      end
    end
    // A new address phase is only taken while the bus is ready.
    if (HREADY) begin
      xfer_next.valid = addr_phase;
      xfer_next.write = HWRITE;
      xfer_next.offset = word_offset(HADDR);
      // Read data is registered ahead of its data phase.
      rdata_next = bss_pkg::BSS_SLEEP_READ;
      if (addr_phase && !HWRITE &&
          word_offset(HADDR) != bss_pkg::BSS_OFF_SLEEP) begin
        rdata_next = 32'h0000_0000;
        rdata_next[IRQ_WIDTH-1:0] = wake_en_next;
      end
    end
  end

  // Register every group; reset clears enables, gate and ack.
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      xfer_reg <= '0;
      wake_en_reg <= bss_pkg::BSS_WAKE_RESET[IRQ_WIDTH-1:0];
      rdata_reg <= bss_pkg::BSS_WAKE_RESET;
      sleep_reg <= bss_pkg::BSS_RUN;
      dbg_reg <= bss_pkg::BSS_DBG_IDLE;
    end else begin
      xfer_reg <= xfer_next;
      wake_en_reg <= wake_en_next;
      rdata_reg <= rdata_next;
      sleep_reg <= sleep_next;
      dbg_reg <= dbg_next;
    end
  end

  // Ready is low on the first stall cycle and while gated or released.
  always_comb begin
    HREADYOUT = !((sleep_reg == bss_pkg::BSS_RUN) && sleep_read &&
      !wake_request) && (sleep_reg != bss_pkg::BSS_STALL) &&
      (sleep_reg != bss_pkg::BSS_GATED) &&
      (sleep_reg != bss_pkg::BSS_RELEASE);
    HRESP = bss_pkg::BSS_RESP_OKAY;
    HRDATA = rdata_reg;
    // The gate closes in the cycle right after the core saw ready low,
    // so the stall state already counts as gated.
    SLEEP_GATE = (sleep_reg == bss_pkg::BSS_STALL) ||
      (sleep_reg == bss_pkg::BSS_GATED);
    DEBUG_POWERUP_ACK = dbg_reg == bss_pkg::BSS_DBG_ACK;
  end

endmodule

// >>> bench/bss_controller_sva.sv
/*
  Checker for the sleep controller's bus stall and gate outputs.
  Assumes it is bound to the controller and sees only its ports.
*/
`timescale 1ns/1ps
module bss_controller_sva (
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic HWRITE,
  input wire logic [1:0] HTRANS,
  input wire logic HREADY,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic [31:0] HRDATA,
  input wire logic NMI,
  input wire logic DEBUG_POWERUP_REQUEST,
  input wire logic DEBUG_POWERUP_ACK,
  input wire logic SLEEP_GATE
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (RESET);
  // High while a read of the sleep entry register is being taken.
  logic rd0;
  assign rd0 = HSEL && HREADY && HTRANS[1] && !HWRITE && HADDR[3:2] == 2'h0;
  // A sleep read taken on this edge.
  sequence sleep_rd;
    rd0;
  endsequence
  // Gate already low, then the stalled read ends with its data.
  sequence release_seq;
    !HREADYOUT ##1 (HREADYOUT && HRDATA == bss_pkg::BSS_SLEEP_READ);
  endsequence
  resp_okay_a: assert property (HRESP == bss_pkg::BSS_RESP_OKAY)
    else $error("response not okay");
  stall_source_a: assert property ($fell(HREADYOUT) |-> $past(rd0))
    else $error("stall without a sleep read");
  gate_late_a: assert property ($rose(SLEEP_GATE) |->
    !HREADYOUT && !$past(HREADYOUT) && $past(rd0, 2))
    else $error("gate not one cycle after stall");
  gate_stall_a: assert property (SLEEP_GATE |-> !HREADYOUT)
    else $error("ready high while gated");
  wake_order_a: assert property ($fell(SLEEP_GATE) |-> release_seq)
    else $error("wake release order wrong");
  nmi_wake_a: assert property ((NMI[*4] ##0 sleep_rd) |=>
    !SLEEP_GATE throughout (##[0:2] HREADYOUT))
    else $error("slept with nmi pending");
  dbg_wake_a: assert property ((DEBUG_POWERUP_REQUEST[*3] ##0 SLEEP_GATE)
    |-> ##[1:3] !SLEEP_GATE)
    else $error("debug request did not wake");
  ack_awake_a: assert property (DEBUG_POWERUP_ACK |-> !SLEEP_GATE)
    else $error("ack while gated");
  ack_hold_a: assert property (DEBUG_POWERUP_ACK && DEBUG_POWERUP_REQUEST
    |=> DEBUG_POWERUP_ACK)
    else $error("ack dropped under request");
endmodule

bind bss_controller bss_controller_sva u_sva (
  .MCLK(MCLK), .RESET(RESET), .HSEL(HSEL), .HADDR(HADDR),
  .HWRITE(HWRITE), .HTRANS(HTRANS), .HREADY(HREADY),
  .HREADYOUT(HREADYOUT), .HRESP(HRESP), .HRDATA(HRDATA), .NMI(NMI),
  .DEBUG_POWERUP_REQUEST(DEBUG_POWERUP_REQUEST),
  .DEBUG_POWERUP_ACK(DEBUG_POWERUP_ACK), .SLEEP_GATE(SLEEP_GATE)
);

// >>> bench/bss_core_model.sv
/*
  Core bus model: issues single transfers to the controller.
  Assumes it is the only master and the controller the only slave.
*/
`timescale 1ns/1ps
module bss_core_model (
  input wire logic MCLK,
  input wire logic HREADYOUT,
  input wire logic [31:0] HRDATA,
  output logic HSEL,
  output logic [31:0] HADDR,
  output logic HWRITE,
  output logic [1:0] HTRANS,
  output logic [31:0] HWDATA
);
  // Bus idle at time zero.
  initial begin
    HSEL = 1'b0;
    HADDR = 32'h0;
    HWRITE = 1'b0;
    HTRANS = 2'h0;
    HWDATA = 32'h0;
  end
  // Address phase, then data phase held until ready is seen high.
  task automatic xfer(input logic wr, input logic [31:0] a,
    input logic [31:0] wd, output logic [31:0] rd, output int n);
    // Ready as it stood in the data phase cycle just looked at.
    logic seen;
    @(posedge MCLK);
    HSEL <= 1'b1;
    HTRANS <= bss_pkg::BSS_TRANS_NONSEQ;
    HADDR <= a;
    HWRITE <= wr;
    HWDATA <= ~HWDATA;
    @(posedge MCLK);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HADDR <= ~a;
    HWDATA <= wd;
    n = 0;
    // The core stands still while its clock is gated.
    // Ready and read data are taken mid-cycle, where they have settled
    // for the coming edge; looking at the edge itself would race the
    // registers that update there.
    do begin
      @(negedge MCLK);
      n++;
      seen = HREADYOUT;
      rd = HRDATA;
      @(posedge MCLK);
    end while (seen !== 1'b1 && n < 500);
  endtask
endmodule

// >>> bench/bss_controller_bench.sv
/*
  Self-checking bench for the sleep controller.
  Assumes the core model is the only bus master.
*/
`timescale 1ns/1ps
module bss_controller_bench;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic hsel, hwrite, hready, hreadyout, hresp, gate, ack;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rd, d;
  logic [31:0] irq = 32'h0;
  logic nmi = 1'b0;
  logic dreq = 1'b0;
  logic [31:0] en_model = 32'h0;
  int bad_count = 0;
  int n_checks = 0;
  int w, op;

  // Free-running bus clock, 100 ns period.
  always #50 mclk = ~mclk;
  assign hready = hreadyout;

  bss_core_model u_bss_core_model (.MCLK(mclk), .HREADYOUT(hreadyout),
    .HRDATA(hrdata), .HSEL(hsel), .HADDR(haddr), .HWRITE(hwrite),
    .HTRANS(htrans), .HWDATA(hwdata));

  bss_controller u_bss_controller (.MCLK(mclk), .RESET(reset),
    .HSEL(hsel), .HADDR(haddr), .HWRITE(hwrite), .HTRANS(htrans),
    .HSIZE(3'h2), .HBURST(3'h0), .HWDATA(hwdata), .HREADY(hready),
    .HREADYOUT(hreadyout), .HRESP(hresp), .HRDATA(hrdata), .IRQ(irq),
    .NMI(nmi), .DEBUG_POWERUP_REQUEST(dreq), .DEBUG_POWERUP_ACK(ack),
    .SLEEP_GATE(gate));

  // Compares a seen value with the expected one and counts both.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Prints the verdict and ends the run.
  task automatic end_of_test();
    if (bad_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // One transfer to a register offset.
  task automatic bus(input logic wr, input logic [3:0] off,
    input logic [31:0] wd);
    u_bss_core_model.xfer(wr, {28'h4000000, off}, wd, rd, w);
  endtask

  // Sleep, wake by an enabled line, the nmi or a debug request.
  task automatic nap(input int kind);
    bus(1'b1, 4'h8, 32'hffffffff);
    en_model = 32'h1 << $urandom_range(31, 0);
    bus(1'b1, 4'h4, en_model);
    fork
      bus(1'b0, 4'h0, 32'h0);
      begin
        repeat (8) @(negedge mclk);
        check({31'h0, gate}, 32'h1);
        @(posedge mclk);
        irq <= ~en_model;
        repeat (6) @(negedge mclk);
        check({31'h0, gate}, 32'h1);
        @(posedge mclk);
        if (kind == 0) irq <= 32'hffffffff;
        if (kind == 1) nmi <= 1'b1;
        if (kind == 2) dreq <= 1'b1;
      end
    join
    check(rd, bss_pkg::BSS_SLEEP_READ);
    check({31'h0, w > 14 && w < 21}, 32'h1);
    bus(1'b0, 4'h0, 32'h0);
    check(w, 32'h1);
    @(negedge mclk);
    check({31'h0, ack}, {31'h0, kind == 2});
    @(posedge mclk);
    irq <= 32'h0;
    nmi <= 1'b0;
    dreq <= 1'b0;
    repeat (6) @(negedge mclk);
    check({31'h0, ack}, 32'h0);
  endtask

  initial begin
    void'($urandom(32'hbf69));
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    @(negedge mclk);
    check({28'h0, hreadyout, hresp, ack, gate}, 32'h8);
    bus(1'b0, 4'h4, 32'h0);
    check(rd, bss_pkg::BSS_WAKE_RESET);
    // Random writes to every offset, each followed by a read back.
    for (int i = 0; i < 14; i++) begin
      d = $urandom;
      op = $urandom_range(3, 0);
      bus(1'b1, 4'(op * 4), d);
      check(w, 32'h1);
      if (op == 1) en_model = en_model | d;
      if (op == 2) en_model = en_model & ~d;
      bus(1'b0, $urandom_range(1, 0) ? 4'h8 : 4'h4, 32'h0);
      check(rd, en_model);
    end
    // The unused fourth word reads back the enable vector as well.
    bus(1'b0, 4'hc, 32'h0);
    check(rd, en_model);
    for (int k = 0; k < 3; k++) nap(k);
    @(posedge mclk);
    reset <= 1'b1;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    bus(1'b0, 4'h8, 32'h0);
    check(rd, bss_pkg::BSS_WAKE_RESET);
    end_of_test();
  end

  // Cuts a hang short well past the expected run length.
  initial begin
    #200000;
    bad_count++;
    end_of_test();
  end
endmodule
